// ===== hw/tx_waveform_shaping_config.sv
// apb register bank and edge sequencer for the transmitter drivers
// assumes carrier, carrier tick and modulation request come from
// logic on pclk; bus master follows apb with one setup cycle
// assumes clk_en on the same clock; low freezes the bus as well
// Behaviour
// [R01] double flag set: each transition state lasts two carrier cycles, else one
// [R02] five-bit count sets number of states in rising and falling edges
// [R03] scheme bit zero gives three driver levels, one gives two levels
// [R04] first driver output inverted when its inversion bit is set
// [R05] second driver output inverted when its inversion bit is set
// [R06] first driver carrier shifted half a period when its phase bit set
// [R07] second driver carrier shifted half a period when its phase bit set
// [R08] software writes reserved bits as zero and ignores their read value
`timescale 1ns/1ps
`default_nettype none

module tx_waveform_shaping_config (
	// clock, reset, enable
	input  wire logic                                pclk,
	input  wire logic                                presetn,
	input  wire logic                                clk_en,
	// apb slave
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [tx_shaping_pkg::APB_ADDR_W-1:0] paddr,
	input  wire logic [31:0]                         pwdata,
	input  wire logic [3:0]                          pstrb,
	output logic      [31:0]                         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	// transmitter timing
	input  wire logic                                carrier_in,
	input  wire logic                                carrier_tick,
	input  wire logic                                mod_request,
	// driver outputs
	output tx_shaping_pkg::drv_t                     first_antenna_driver,
	output tx_shaping_pkg::drv_t                     second_antenna_driver,
	output tx_shaping_pkg::shape_t                   shape,
	output tx_shaping_pkg::tx_raw_t                  raw_fields
);
	import tx_shaping_pkg::*;

	// ****************************************************
	// address decode
	// ****************************************************

	// bank layout, byte address is four times the index
	//   slot 0   index 0x515  edge length, double flag and count
	//   slot 1   index 0x516  residual amplitude in pause
	//   slot 2   index 0x58C  driver level scheme
	//   slot 3   index 0x58D  driver inversion and phase
	//   slot 4   index 0x58E  carrier and modulation clock select
	//   slot 5   index 0x58F  default and transition clock select
	//   slot 6   index 0x590  low side strength, modulated
	//   slot 7   index 0x591  low side strength, carrier
	//   slot 8   index 0x592  high side strength
	//   slot 9   index 0x593  force zero threshold
	//   slot 10  index 0x594  target scale
	//   slot 11  index 0x595  phase shift tens
	//   slot 12  index 0x596  phase shift units
	// misaligned or unmapped addresses answer with pslverr
	// the gap between the two groups is not decoded

	// index is the word address; the range test covers the
	// contiguous global group in one compare pair
	// maps a byte address to {hit, slot}
	function automatic logic [4:0] decode_slot(input logic [APB_ADDR_W-1:0] a);
		logic [IDX_W-1:0] idx;
		logic [IDX_W-1:0] ofs;
		idx = a[APB_ADDR_W-1:2];
		ofs = idx - IDX_SCHEME;
		decode_slot = 5'h00;
		if (a[1:0] != 2'b00) begin
			decode_slot = 5'h00;
		end else if (idx == IDX_EDGE_LEN) begin
			decode_slot = {1'b1, SLOT_EDGE_LEN};
		end else if (idx == IDX_RESIDUAL) begin
			decode_slot = {1'b1, SLOT_RESIDUAL};
		end else if (idx >= IDX_SCHEME && idx <= IDX_PH_UNITS) begin
			decode_slot = {1'b1, 4'(ofs[3:0] + SLOT_SCHEME)};
		end
	endfunction

	logic [7:0]  reg_q [NUM_REGS];
	logic        ready_q;
	logic        ready_d;
	logic        slverr_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	wire  [4:0]  dec     = decode_slot(paddr);
	wire         hit     = dec[4];
	wire  [3:0]  slot    = dec[3:0];
	wire         access  = psel & penable;
	wire         finish  = access & ready_q;
	wire         wr_go   = finish & pwrite & hit & pstrb[0];

	// bus timing, one wait state per transfer:
	//   setup cycle, psel high and penable low
	//   first access cycle, pready still low
	//   second access cycle, pready high with data or error
	// write lands on the edge that samples pready high
	// pstrb[0] low drops the write without error
	// low clk_en holds pready at its current value, so a pready still low stretches the access

	// answer one cycle into the access phase
	assign ready_d = access & ~ready_q;
	assign rdata_d = (hit & ~pwrite) ? {24'h000000, reg_q[slot]} : 32'h00000000;

	// ****************************************************
	// bus response flops
	// ****************************************************

	// read data is forced to zero outside the answer cycle,
	// so a stale value never shows on prdata
	// pslverr rides with pready on an unmapped address
	// ready, error and read data registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_q  <= 1'b0;
			slverr_q <= 1'b0;
			rdata_q  <= 32'h00000000;
		end else if (clk_en) begin
			ready_q  <= ready_d;
			slverr_q <= ready_d & ~hit;
			rdata_q  <= ready_d ? rdata_d : 32'h00000000;
		end
	end

	assign prdata  = rdata_q;
	assign pready  = ready_q;
	assign pslverr = slverr_q;

	// ****************************************************
	// register storage
	// ****************************************************

	// every slot clears to zero on reset; the bank holds no
	// default image, so software loads it after each reset
	// writes touch only the low byte of pwdata
	// one write enable per slot, matched on the decoded slot
	// reserved bits never stored, so they read as zero
	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi = gi + 1) begin : g_reg
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					reg_q[gi] <= REG_RESET;
				end else if (clk_en && wr_go && slot == 4'(gi)) begin
					reg_q[gi] <= pwdata[7:0] & REG_MASK[gi]; // see [R08]
				end
			end
		end
	endgenerate

	// ****************************************************
	// configuration fields
	// ****************************************************

	// shaping field positions come from the package; reserved bits
	// are already zero in storage, so no masking here
	// shaping controls taken from the bank
	wire        edge_double  = reg_q[SLOT_EDGE_LEN][EDGE_DOUBLE_BIT];
	wire  [4:0] edge_count   = reg_q[SLOT_EDGE_LEN][EDGE_COUNT_MSB:0];
	wire  [7:0] residual     = reg_q[SLOT_RESIDUAL];
	wire        two_level    = reg_q[SLOT_SCHEME][SCHEME_BIT];
	wire        inv_one      = reg_q[SLOT_INV][INV_ONE_BIT];
	wire        inv_two      = reg_q[SLOT_INV][INV_TWO_BIT];
	wire        phase_one    = reg_q[SLOT_INV][PHASE_ONE_BIT];
	wire        phase_two    = reg_q[SLOT_INV][PHASE_TWO_BIT];

	// raw analog fields, one named wire per field
	wire  [2:0] sel_carrier      = reg_q[4][6:4];
	wire  [2:0] sel_modulation   = reg_q[4][2:0];
	wire  [2:0] sel_default      = reg_q[5][6:4];
	wire  [2:0] sel_transition   = reg_q[5][2:0];
	wire  [4:0] strength_low_mod = reg_q[6][4:0];
	wire  [4:0] strength_low_car = reg_q[7][4:0];
	wire  [4:0] strength_high    = reg_q[8][4:0];
	wire  [6:0] zero_threshold   = reg_q[9][6:0];
	wire  [7:0] scale_target     = reg_q[10];
	wire  [4:0] shift_tens       = reg_q[11][4:0];
	wire  [3:0] shift_units      = reg_q[12][3:0];

	// raw analog fields registered, one clock behind the bank
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_fields <= '0;
		end else if (clk_en) begin
			raw_fields <= '{
				carrier_clock_select:        sel_carrier,
				modulation_clock_select:     sel_modulation,
				default_clock_select:        sel_default,
				transition_clock_select:     sel_transition,
				low_side_strength_modulated: strength_low_mod,
				low_side_strength_carrier:   strength_low_car,
				high_side_strength:          strength_high,
				force_zero_threshold:        zero_threshold,
				target_scale:                scale_target,
				phase_shift_tens:            shift_tens,
				phase_shift_units:           shift_units};
		end
	end

	// ****************************************************
	// edge sequencer
	// ****************************************************

	edge_state_t state_q;
	edge_state_t state_d;
	logic [4:0]  step_q;
	logic [4:0]  step_d;
	logic        dwell_q;
	logic        dwell_d;

	// state codes step one bit at a time around the loop:
	//   on 00, fall 01, off 11, rise 10
	// so a late sample never sees a code off the path, except when a count of zero jumps between on 00 and off 11

	// sequencer walk, count two, no doubling:
	//   on with mod_request high, fall step 0 next edge
	//   carrier tick, fall step 1
	//   carrier tick, off, drivers paused
	//   off with mod_request low, rise step 0
	//   two more ticks, back to on
	// a count of zero skips the edge states both ways
	// mod_request is only looked at in the on and off states
	// doubling holds each step for two ticks via dwell_q

	// a state ends after one tick, or two when doubling
	wire state_done = carrier_tick & (~edge_double | dwell_q); // see [R01]
	// last of the counted states, forced true when count is zero
	wire last_step  = (edge_count == 5'h00) |
	                  (step_q == 5'(edge_count - 5'h01)); // see [R02]
	wire in_edge    = (state_q == ST_FALL) | (state_q == ST_RISE);

	// next state of the sequencer
	always_comb begin
		state_d = state_q;
		step_d  = step_q;
		dwell_d = dwell_q;
		unique case (state_q)
			ST_ON: begin
				if (mod_request) begin
					state_d = (edge_count == 5'h00) ? ST_OFF : ST_FALL; // see [R02]
					step_d  = 5'h00;
					dwell_d = 1'b0;
				end
			end
			ST_FALL, ST_RISE: begin
				if (carrier_tick) begin
					dwell_d = edge_double & ~dwell_q; // see [R01]
				end
				if (state_done) begin
					dwell_d = 1'b0;
					if (last_step) begin
						state_d = (state_q == ST_FALL) ? ST_OFF : ST_ON;
						step_d  = 5'h00;
					end else begin
						step_d  = step_q + 5'h01;
					end
				end
			end
			ST_OFF: begin
				if (!mod_request) begin
					state_d = (edge_count == 5'h00) ? ST_ON : ST_RISE; // see [R02]
					step_d  = 5'h00;
					dwell_d = 1'b0;
				end
			end
		endcase
	end

	// sequencer flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_ON;
			step_q  <= 5'h00;
			dwell_q <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			step_q  <= step_d;
			dwell_q <= dwell_d;
		end
	end

	// ****************************************************
	// shape report
	// ****************************************************

	// shape reports state and step one clock late, for the
	// analog ramp that realises the edge; amplitude is full
	// in the on state and the residual level elsewhere
	// amplitude target of the current state
	wire [7:0] ampl_d = (state_q == ST_OFF) ? residual :
	                    in_edge             ? residual : AMPL_FULL;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shape <= '{state: ST_ON, step: 5'h00, amplitude: AMPL_FULL};
		end else if (clk_en) begin
			shape <= '{state: state_q, step: step_q, amplitude: ampl_d};
		end
	end

	// ****************************************************
	// antenna drivers
	// ****************************************************

	// driver levels per state and scheme:
	//   on or edge         level follows carrier, mid low
	//   off, three levels  level low, mid high
	//   off, two levels    level low, mid low
	// inversion applies last, so an inverted driver idles high
	// phase shift is carrier inversion, exact on a square carrier
	// drivers lag carrier_in by one clock, as shape lags state

	// carrier of each driver, half period shift by inversion of phase
	wire car_one   = carrier_in ^ phase_one; // see [R06]
	wire car_two   = carrier_in ^ phase_two; // see [R07]
	wire paused    = (state_q == ST_OFF);
	// three levels park at mid during the pause, two levels drive low
	wire mid_d     = ~two_level & paused; // see [R03]
	wire lvl_one   = ~paused & car_one;   // see [R03]
	wire lvl_two   = ~paused & car_two;   // see [R03]

	// driver flops with output inversion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_antenna_driver  <= '0;
			second_antenna_driver <= '0;
		end else if (clk_en) begin
			first_antenna_driver  <= '{mid: mid_d, level: lvl_one ^ inv_one}; // see [R04]
			second_antenna_driver <= '{mid: mid_d, level: lvl_two ^ inv_two}; // see [R05]
		end
	end

endmodule

`default_nettype wire

// ===== include/tx_shaping_pkg.sv
// package of the transmitter waveform shaping configuration bank
// assumes a byte-wide register per aligned apb word
package tx_shaping_pkg;

	// ****************************************************
	// bus and register map
	// ****************************************************
	localparam int          APB_ADDR_W = 16;
	localparam int          IDX_W      = APB_ADDR_W - 2;
	localparam int          NUM_REGS   = 13;
	localparam logic [13:0] IDX_EDGE_LEN  = 14'h0515;
	localparam logic [13:0] IDX_RESIDUAL  = 14'h0516;
	localparam logic [13:0] IDX_SCHEME    = 14'h058C;
	localparam logic [13:0] IDX_INV_PHASE = 14'h058D;
	localparam logic [13:0] IDX_CLK_ONE   = 14'h058E;
	localparam logic [13:0] IDX_CLK_TWO   = 14'h058F;
	localparam logic [13:0] IDX_GSN_MOD   = 14'h0590;
	localparam logic [13:0] IDX_GSN_CW    = 14'h0591;
	localparam logic [13:0] IDX_GSP       = 14'h0592;
	localparam logic [13:0] IDX_FRC_ZERO  = 14'h0593;
	localparam logic [13:0] IDX_SCALE     = 14'h0594;
	localparam logic [13:0] IDX_PH_TENS   = 14'h0595;
	localparam logic [13:0] IDX_PH_UNITS  = 14'h0596;
	// slot numbers inside the bank
	localparam logic [3:0]  SLOT_EDGE_LEN = 4'h0;
	localparam logic [3:0]  SLOT_RESIDUAL = 4'h1;
	localparam logic [3:0]  SLOT_SCHEME   = 4'h2;
	localparam logic [3:0]  SLOT_INV      = 4'h3;

	// ****************************************************
	// writable bit masks and values after reset
	// ****************************************************
	localparam logic [7:0] REG_MASK [NUM_REGS] = '{
		8'h9F, 8'hFF, 8'h01, 8'h33, 8'h77, 8'h77, 8'h1F,
		8'h1F, 8'h1F, 8'h7F, 8'hFF, 8'h1F, 8'h0F};
	localparam logic [7:0] REG_RESET  = 8'h00;

	// ****************************************************
	// field positions
	// ****************************************************
	localparam int EDGE_DOUBLE_BIT = 7;
	localparam int EDGE_COUNT_MSB  = 4;
	localparam int SCHEME_BIT      = 0;
	localparam int INV_ONE_BIT     = 5;
	localparam int INV_TWO_BIT     = 4;
	localparam int PHASE_ONE_BIT   = 1;
	localparam int PHASE_TWO_BIT   = 0;
	localparam logic [7:0] AMPL_FULL = 8'hFF;

	// ****************************************************
	// types
	// ****************************************************
	typedef enum logic [1:0] {
		ST_ON   = 2'b00,
		ST_FALL = 2'b01,
		ST_OFF  = 2'b11,
		ST_RISE = 2'b10
	} edge_state_t;

	typedef struct packed {
		logic mid;
		logic level;
	} drv_t;

	typedef struct packed {
		edge_state_t state;
		logic [4:0]  step;
		logic [7:0]  amplitude;
	} shape_t;

	typedef struct packed {
		logic [2:0] carrier_clock_select;
		logic [2:0] modulation_clock_select;
		logic [2:0] default_clock_select;
		logic [2:0] transition_clock_select;
		logic [4:0] low_side_strength_modulated;
		logic [4:0] low_side_strength_carrier;
		logic [4:0] high_side_strength;
		logic [6:0] force_zero_threshold;
		logic [7:0] target_scale;
		logic [4:0] phase_shift_tens;
		logic [3:0] phase_shift_units;
	} tx_raw_t;

endpackage

// ===== tb/tx_shaping_monitor.sv
// checker for the shaping configuration bank, bound to its top
// assumes clk_en is held high by the bench
`timescale 1ns/1ps
`default_nettype none
module tx_shaping_monitor
	import tx_shaping_pkg::*;
(
	// clock and reset
	input wire logic                   pclk,
	input wire logic                   presetn,
	// apb side
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic [31:0]            prdata,
	// transmitter side
	input wire logic                   carrier_in,
	input wire tx_shaping_pkg::drv_t   first_antenna_driver,
	input wire tx_shaping_pkg::drv_t   second_antenna_driver,
	input wire tx_shaping_pkg::shape_t shape
);
	import tx_shaping_pkg::*;
	logic carrier_q;

	// ****************************************
	// helper logic
	// ****************************************
	// carrier delayed to line up with the registered drivers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carrier_q <= 1'b0;
		end else begin
			carrier_q <= carrier_in;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable;
	endsequence
	// no bank write in the last three cycles
	sequence quiet_s;
		!pready [*3];
	endsequence

	// ****************************************
	// assertions
	// ****************************************
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_ONE_WAIT: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
		else $error("pready without access");
	AST_ERR_PAIR: assert property (pslverr |-> pready)
		else $error("pslverr outside answer");
	AST_DATA_IDLE: assert property (!pready || pslverr |-> prdata == 32'h0)
		else $error("prdata not zero");
	AST_MID_PAUSE: assert property (
		first_antenna_driver.mid || second_antenna_driver.mid |-> shape.state == ST_OFF)
		else $error("mid level outside pause");
	AST_OFF_HOLD: assert property (
		quiet_s ##0 (shape.state == ST_OFF && $past(shape.state) == ST_OFF)
		|-> $stable({first_antenna_driver.level, second_antenna_driver.level}))
		else $error("driver moved during pause");
	AST_TRACK_ONE: assert property (
		quiet_s ##0 (shape.state != ST_OFF && $past(shape.state) != ST_OFF)
		|-> $stable(first_antenna_driver.level ^ carrier_q))
		else $error("first driver lost carrier");
	AST_TRACK_TWO: assert property (
		quiet_s ##0 (shape.state != ST_OFF && $past(shape.state) != ST_OFF)
		|-> $stable(second_antenna_driver.level ^ carrier_q))
		else $error("second driver lost carrier");
endmodule

bind tx_waveform_shaping_config tx_shaping_monitor tx_shaping_monitor_inst (
	.pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata,
	.carrier_in, .first_antenna_driver, .second_antenna_driver, .shape);
`default_nettype wire

// ===== tb/tx_waveform_shaping_config_tb.sv
// testbench for the shaping configuration bank
// assumes the bank package and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tx_waveform_shaping_config_tb;
	import tx_shaping_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er, c;
	logic [15:0] paddr = 16'h0, a;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'h0;
	logic        carrier_in = 1'b0, carrier_tick = 1'b0, mod_request = 1'b0;
	logic [1:0]  cc = 2'h0;
	logic [7:0]  iv [6] = '{8'h00, 8'h20, 8'h10, 8'h02, 8'h01, 8'h33};
	drv_t        drv1, drv2;
	shape_t      shape;
	tx_raw_t     raw;
	int          n_mismatch = 0, check_count = 0;

	tx_waveform_shaping_config tx_waveform_shaping_config_inst (
		.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .carrier_in, .carrier_tick, .mod_request,
		.first_antenna_driver(drv1), .second_antenna_driver(drv2), .shape, .raw_fields(raw));

	// ****************************************
	// clock, carrier and tasks
	// ****************************************
	always #25 pclk = ~pclk;
	// carrier of four clocks with one tick per period
	always @(posedge pclk) begin
		cc <= cc + 2'h1;
		carrier_in <= cc[1];
		carrier_tick <= (cc == 2'h3);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [15:0] ad, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		rd = prdata;
		er = pslverr;
		if (n >= 40) n_mismatch++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// edge length run: fall to pause and rise back, counting ticks
	task automatic erun(input logic [7:0] ev, input logic sc, input int ex);
		int t;
		edge_state_t tgt;
		xfer(1'b1, 16'h1454, {24'h0, ev}, 4'hF);
		xfer(1'b1, 16'h1630, {31'h0, sc}, 4'hF);
		for (int p = 0; p < 2; p++) begin
			do @(posedge pclk); while (carrier_tick !== 1'b1);
			mod_request <= (p == 0);
			tgt = (p == 0) ? ST_OFF : ST_ON;
			t = 0;
			for (int k = 0; k < 300 && shape.state !== tgt; k++) begin
				@(posedge pclk);
				if (carrier_tick) t++;
				#1;
			end
			chk(32'(t), 32'(ex));
			if (p == 0) begin
				chk({28'h0, drv1.mid, drv2.mid, drv1.level, drv2.level}, {28'h0, ~sc, ~sc, 2'b11});
				chk({24'h0, shape.amplitude}, 32'h5A);
			end
		end
		$display("test edge run done");
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < NUM_REGS; i++) begin
			a = 16'(4 * (i < 2 ? 32'h515 + i : 32'h58A + i));
			xfer(1'b0, a, 32'h0, 4'h0);
			chk(rd, 32'h0);
			xfer(1'b1, a, {24'h0, REG_MASK[i]}, 4'hF);
			xfer(1'b1, a, 32'h0, 4'hE);
			xfer(1'b0, a, 32'h0, 4'h0);
			chk(rd, {24'h0, REG_MASK[i]});
		end
		chk({raw.target_scale, 20'h0, raw.phase_shift_units}, 32'hFF00_000F);
		xfer(1'b0, 16'h0000, 32'h0, 4'h0);
		chk({rd[30:0], er}, 32'h1);
		xfer(1'b0, 16'h1456, 32'h0, 4'h0);
		chk({rd[30:0], er}, 32'h1);
		$display("test registers done");
		xfer(1'b1, 16'h1458, 32'h5A, 4'hF);
		foreach (iv[j]) begin
			xfer(1'b1, 16'h1634, {24'h0, iv[j]}, 4'hF);
			repeat (2) begin
				repeat (2) @(posedge pclk);
				c = carrier_in;
				#1;
				chk({drv1.level, drv2.level}, {c ^ iv[j][1] ^ iv[j][5], c ^ iv[j][0] ^ iv[j][4]});
			end
		end
		$display("test drivers done");
		erun(8'h02, 1'b0, 2);
		erun(8'h9F, 1'b1, 62);
		erun(8'h00, 1'b0, 0);
		erun(8'h1F, 1'b0, 31);
		finish_test();
	end
	// watchdog against a hang
	initial begin
		repeat (8000) @(posedge pclk);
		n_mismatch++;
		finish_test();
	end
endmodule
`default_nettype wire
